// *** pkg/exec_pkg.sv ***
// shared types and constants for the arithmetic, multiply and branch execution unit
package exec_pkg;

	// widths and bit positions
	localparam int PC_W = 22;
	localparam int SIGN_BIT = 7;
	localparam int HALF_BIT = 3;
	localparam int WORD_SIGN = 15;

	// cycle counts per operation class
	localparam logic [2:0] CYC_SINGLE = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
	localparam logic [2:0] CYC_PTR_CALL = 3'h4;
	localparam logic [2:0] CYC_EXT_CALL = 3'h5;
	localparam logic [2:0] CYC_DIRECT_CALL = 3'h5;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

	// program counter advances in words
	localparam logic [21:0] ADV_NEXT = 22'h000001;
	localparam logic [21:0] ADV_SKIP_ONE = 22'h000002;
	localparam logic [21:0] ADV_SKIP_TWO = 22'h000003;
	localparam logic [21:0] ADV_CALL_WORDS = 22'h000002;

	// constants and flag masks, bit order i t h s v n z c
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] MASK_ADD_SUB = 8'h2f;
	localparam logic [7:0] MASK_WORD = 8'h1f;
	localparam logic [7:0] MASK_LOGIC = 8'h0e;
	localparam logic [7:0] MASK_MUL = 8'h03;
	localparam logic [7:0] MASK_NONE = 8'h00;

	typedef enum logic [5:0] {
		add_reg_op, add_carry_reg_op, word_add_immediate_op, subtract_reg_op,
		subtract_carry_reg_op, subtract_const_op, subtract_carry_const_op,
		word_subtract_immediate_op, and_reg_op, and_const_op, or_reg_op, or_const_op,
		xor_reg_op, bit_set_mask_op, bit_clear_mask_op, zero_minus_test_op,
		unsigned_multiply_op, signed_multiply_op, mixed_multiply_op,
		fraction_unsigned_multiply_op, fraction_signed_multiply_op,
		fraction_mixed_multiply_op, pointer_jump_op, extended_pointer_jump_op,
		pointer_call_op, extended_pointer_call_op, direct_call_op, equal_skip_op,
		immediate_compare_op, reg_bit_clear_skip_op, reg_bit_set_skip_op,
		io_bit_clear_skip_op, io_bit_set_skip_op
	} op_type;

	typedef enum logic {st_idle, st_busy} state_type;

	typedef struct packed {
		logic i, t, h, s, v, n, z, c;
	} flags_type;

	typedef struct packed {
		op_type op;
		logic [7:0] rd_val;
		logic [7:0] rdh_val;
		logic [7:0] rr_val;
		logic [7:0] imm;
		logic [7:0] io_val;
		logic carry_in;
		logic [15:0] z_ptr;
		logic [7:0] jump_extension_register;
		logic [21:0] abs_addr;
		logic [21:0] pc;
		logic [2:0] bit_sel;
		logic next_two_word;
	} request_type;

	typedef struct packed {
		logic [7:0] rd_res;
		logic [7:0] rdh_res;
		logic [15:0] product_register_pair;
		flags_type flags;
		logic [7:0] flag_mask;
		logic rd_wr;
		logic pair_wr;
		logic prod_wr;
		logic push_ret;
		logic [21:0] pc_next;
		logic [21:0] ret_addr;
	} result_type;

endpackage : exec_pkg

// *** src/alu_branch_exec.sv ***
// execution unit for arithmetic, logic, multiply, indirect jump/call and skip operations
`timescale 1ns/1ps

module alu_branch_exec (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic issue,
	input wire exec_pkg::request_type req,
	output logic ready,
	output logic done,
	output exec_pkg::result_type res
);

	////////////////////////////////////////////////////////////////////////////////
	// operation classification

	function automatic logic uses_imm(input exec_pkg::op_type op);
		return op inside {exec_pkg::subtract_const_op, exec_pkg::subtract_carry_const_op,
			exec_pkg::and_const_op, exec_pkg::or_const_op, exec_pkg::bit_set_mask_op,
			exec_pkg::bit_clear_mask_op, exec_pkg::immediate_compare_op};
	endfunction : uses_imm

	function automatic logic uses_carry(input exec_pkg::op_type op);
		return op inside {exec_pkg::add_carry_reg_op, exec_pkg::subtract_carry_reg_op,
			exec_pkg::subtract_carry_const_op};
	endfunction : uses_carry

	function automatic logic is_skip(input exec_pkg::op_type op);
		return op inside {exec_pkg::equal_skip_op, exec_pkg::reg_bit_clear_skip_op,
			exec_pkg::reg_bit_set_skip_op, exec_pkg::io_bit_clear_skip_op,
			exec_pkg::io_bit_set_skip_op};
	endfunction : is_skip

	function automatic logic is_frac(input exec_pkg::op_type op);
		return op inside {exec_pkg::fraction_unsigned_multiply_op,
			exec_pkg::fraction_signed_multiply_op, exec_pkg::fraction_mixed_multiply_op};
	endfunction : is_frac

	function automatic logic is_mul(input exec_pkg::op_type op);
		return is_frac(op) || op inside {exec_pkg::unsigned_multiply_op,
			exec_pkg::signed_multiply_op, exec_pkg::mixed_multiply_op};
	endfunction : is_mul

	////////////////////////////////////////////////////////////////////////////////
	// operand selection and byte arithmetic

	exec_pkg::op_type op;
	wire logic [7:0] opa = req.rd_val;
	wire logic [7:0] opb = uses_imm(op) ? req.imm : req.rr_val;
	wire logic cin = uses_carry(op) & req.carry_in;
	wire logic [8:0] add9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	wire logic [8:0] sub9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
	wire logic [7:0] add_r = add9[7:0];
	wire logic [7:0] sub_r = sub9[7:0];
	assign op = req.op;

	// carry out of bit 3 and signed overflow, add and subtract forms
	wire logic add_h = (opa[exec_pkg::HALF_BIT] & opb[exec_pkg::HALF_BIT])
		| (opb[exec_pkg::HALF_BIT] & ~add_r[exec_pkg::HALF_BIT])
		| (~add_r[exec_pkg::HALF_BIT] & opa[exec_pkg::HALF_BIT]);
	wire logic add_v = (opa[exec_pkg::SIGN_BIT] & opb[exec_pkg::SIGN_BIT]
		& ~add_r[exec_pkg::SIGN_BIT]) | (~opa[exec_pkg::SIGN_BIT]
		& ~opb[exec_pkg::SIGN_BIT] & add_r[exec_pkg::SIGN_BIT]);
	wire logic sub_h = (~opa[exec_pkg::HALF_BIT] & opb[exec_pkg::HALF_BIT])
		| (opb[exec_pkg::HALF_BIT] & sub_r[exec_pkg::HALF_BIT])
		| (sub_r[exec_pkg::HALF_BIT] & ~opa[exec_pkg::HALF_BIT]);
	wire logic sub_v = (opa[exec_pkg::SIGN_BIT] & ~opb[exec_pkg::SIGN_BIT]
		& ~sub_r[exec_pkg::SIGN_BIT]) | (~opa[exec_pkg::SIGN_BIT]
		& opb[exec_pkg::SIGN_BIT] & sub_r[exec_pkg::SIGN_BIT]);

	// logic results; the clear mask is inverted against all ones
	wire logic [7:0] and_r = opa & opb;
	wire logic [7:0] or_r = opa | opb;
	wire logic [7:0] xor_r = opa ^ req.rr_val;
	wire logic [7:0] clr_r = opa & (exec_pkg::BYTE_ONES - req.imm);
	wire logic [7:0] tst_r = opa & opa;
	wire logic [7:0] lres = (op inside {exec_pkg::and_reg_op, exec_pkg::and_const_op}) ? and_r
		: (op == exec_pkg::xor_reg_op) ? xor_r
		: (op == exec_pkg::bit_clear_mask_op) ? clr_r
		: (op == exec_pkg::zero_minus_test_op) ? tst_r : or_r;

	////////////////////////////////////////////////////////////////////////////////
	// word arithmetic on the high:low pair, constant limited to six bits

	wire logic [15:0] pair = {req.rdh_val, req.rd_val};
	wire logic [15:0] kword = {10'h000, req.imm[5:0]};
	wire logic [15:0] wadd = pair + kword;
	wire logic [15:0] wsub = pair - kword;
	wire logic hi_sign = req.rdh_val[exec_pkg::SIGN_BIT];
	wire logic wadd_v = ~hi_sign & wadd[exec_pkg::WORD_SIGN];
	wire logic wadd_c = hi_sign & ~wadd[exec_pkg::WORD_SIGN];
	wire logic wsub_v = hi_sign & ~wsub[exec_pkg::WORD_SIGN];
	wire logic wsub_c = ~hi_sign & wsub[exec_pkg::WORD_SIGN];
	wire logic [15:0] wres = (op == exec_pkg::word_add_immediate_op) ? wadd : wsub;
	wire logic wres_v = (op == exec_pkg::word_add_immediate_op) ? wadd_v : wsub_v;

	////////////////////////////////////////////////////////////////////////////////
	// multiplier: one shared 9x9 signed array serves all six forms

	wire logic sgn_a = op inside {exec_pkg::signed_multiply_op, exec_pkg::mixed_multiply_op,
		exec_pkg::fraction_signed_multiply_op, exec_pkg::fraction_mixed_multiply_op};
	wire logic sgn_b = op inside {exec_pkg::signed_multiply_op,
		exec_pkg::fraction_signed_multiply_op};
	wire logic signed [8:0] ext_a = {sgn_a & req.rd_val[exec_pkg::SIGN_BIT], req.rd_val};
	wire logic signed [8:0] ext_b = {sgn_b & req.rr_val[exec_pkg::SIGN_BIT], req.rr_val};
	wire logic signed [17:0] prod18 = ext_a * ext_b;
	wire logic [15:0] prod_raw = prod18[15:0];
	wire logic [15:0] prod_fin = is_frac(op) ? {prod_raw[14:0], 1'b0} : prod_raw;

	////////////////////////////////////////////////////////////////////////////////
	// skip decision and program counter targets

	wire logic reg_bit = req.rr_val[req.bit_sel];
	wire logic io_bit = req.io_val[req.bit_sel];
	wire logic skip_take = (op == exec_pkg::equal_skip_op && req.rd_val == req.rr_val)
		|| (op == exec_pkg::reg_bit_clear_skip_op && !reg_bit)
		|| (op == exec_pkg::reg_bit_set_skip_op && reg_bit)
		|| (op == exec_pkg::io_bit_clear_skip_op && !io_bit)
		|| (op == exec_pkg::io_bit_set_skip_op && io_bit);
	wire logic [21:0] pc_seq = req.pc + exec_pkg::ADV_NEXT;
	wire logic [21:0] pc_skip = req.pc + (req.next_two_word ? exec_pkg::ADV_SKIP_TWO
		: exec_pkg::ADV_SKIP_ONE);
	wire logic [21:0] z_target = {6'h00, req.z_ptr};
	wire logic [23:0] ext_full = {req.jump_extension_register, req.z_ptr};
	wire logic [21:0] ext_target = ext_full[21:0];

	// cycles spent by each operation, skips depend on what is skipped
	function automatic logic [2:0] op_cycles(input exec_pkg::op_type o, input logic take,
		input logic two);
		if (is_skip(o) && take)
			return two ? exec_pkg::CYC_SKIP_TWO : exec_pkg::CYC_SKIP_ONE;
		else if (o inside {exec_pkg::word_add_immediate_op, exec_pkg::word_subtract_immediate_op})
			return exec_pkg::CYC_WORD;
		else if (is_mul(o))
			return exec_pkg::CYC_MUL;
		else if (o inside {exec_pkg::pointer_jump_op, exec_pkg::extended_pointer_jump_op})
			return exec_pkg::CYC_PTR_JUMP;
		else if (o == exec_pkg::pointer_call_op)
			return exec_pkg::CYC_PTR_CALL;
		else if (o == exec_pkg::extended_pointer_call_op)
			return exec_pkg::CYC_EXT_CALL;
		else if (o == exec_pkg::direct_call_op)
			return exec_pkg::CYC_DIRECT_CALL;
		return exec_pkg::CYC_SINGLE;
	endfunction : op_cycles

	wire logic [2:0] cycles = op_cycles(op, skip_take, req.next_two_word);

	////////////////////////////////////////////////////////////////////////////////
	// result assembly; flags outside the mask are left to the status keeper

	exec_pkg::result_type res_nxt;
	always_comb begin
		res_nxt = '0;
		res_nxt.pc_next = pc_seq;
		unique case (op)
			exec_pkg::add_reg_op, exec_pkg::add_carry_reg_op: begin
				res_nxt.rd_res = add_r;
				res_nxt.rd_wr = 1'b1;
				res_nxt.flag_mask = exec_pkg::MASK_ADD_SUB;
				res_nxt.flags.h = add_h;
				res_nxt.flags.v = add_v;
				res_nxt.flags.n = add_r[exec_pkg::SIGN_BIT];
				res_nxt.flags.z = (add_r == 8'h00);
				res_nxt.flags.c = add9[8];
			end
			exec_pkg::subtract_reg_op, exec_pkg::subtract_carry_reg_op,
			exec_pkg::subtract_const_op, exec_pkg::subtract_carry_const_op,
			exec_pkg::immediate_compare_op: begin
				res_nxt.rd_res = sub_r;
				res_nxt.rd_wr = (op != exec_pkg::immediate_compare_op);
				res_nxt.flag_mask = exec_pkg::MASK_ADD_SUB;
				res_nxt.flags.h = sub_h;
				res_nxt.flags.v = sub_v;
				res_nxt.flags.n = sub_r[exec_pkg::SIGN_BIT];
				res_nxt.flags.z = (sub_r == 8'h00);
				res_nxt.flags.c = sub9[8];
			end
			exec_pkg::word_add_immediate_op, exec_pkg::word_subtract_immediate_op: begin
				{res_nxt.rdh_res, res_nxt.rd_res} = wres;
				res_nxt.pair_wr = 1'b1;
				res_nxt.flag_mask = exec_pkg::MASK_WORD;
				res_nxt.flags.v = wres_v;
				res_nxt.flags.n = wres[exec_pkg::WORD_SIGN];
				res_nxt.flags.s = wres[exec_pkg::WORD_SIGN] ^ wres_v;
				res_nxt.flags.z = (wres == 16'h0000);
				res_nxt.flags.c = (op == exec_pkg::word_add_immediate_op) ? wadd_c : wsub_c;
			end
			exec_pkg::and_reg_op, exec_pkg::and_const_op, exec_pkg::or_reg_op,
			exec_pkg::or_const_op, exec_pkg::xor_reg_op, exec_pkg::bit_set_mask_op,
			exec_pkg::bit_clear_mask_op, exec_pkg::zero_minus_test_op: begin
				res_nxt.rd_res = lres;
				res_nxt.rd_wr = 1'b1;
				res_nxt.flag_mask = exec_pkg::MASK_LOGIC;
				res_nxt.flags.n = lres[exec_pkg::SIGN_BIT];
				res_nxt.flags.z = (lres == 8'h00);
			end
			exec_pkg::unsigned_multiply_op, exec_pkg::signed_multiply_op,
			exec_pkg::mixed_multiply_op, exec_pkg::fraction_unsigned_multiply_op,
			exec_pkg::fraction_signed_multiply_op, exec_pkg::fraction_mixed_multiply_op: begin
				res_nxt.product_register_pair = prod_fin;
				res_nxt.prod_wr = 1'b1;
				res_nxt.flag_mask = exec_pkg::MASK_MUL;
				res_nxt.flags.z = (prod_fin == 16'h0000);
				res_nxt.flags.c = prod_raw[exec_pkg::WORD_SIGN]; // taken before the shift
			end
			exec_pkg::pointer_jump_op: res_nxt.pc_next = z_target;
			exec_pkg::extended_pointer_jump_op: res_nxt.pc_next = ext_target;
			exec_pkg::pointer_call_op, exec_pkg::extended_pointer_call_op: begin
				res_nxt.pc_next = (op == exec_pkg::pointer_call_op) ? z_target
					: ext_target;
				res_nxt.push_ret = 1'b1;
				res_nxt.ret_addr = pc_seq;
			end
			exec_pkg::direct_call_op: begin
				res_nxt.pc_next = req.abs_addr;
				res_nxt.push_ret = 1'b1;
				res_nxt.ret_addr = req.pc + exec_pkg::ADV_CALL_WORDS; // two-word opcode
			end
			exec_pkg::equal_skip_op, exec_pkg::reg_bit_clear_skip_op,
			exec_pkg::reg_bit_set_skip_op, exec_pkg::io_bit_clear_skip_op,
			exec_pkg::io_bit_set_skip_op: begin
				res_nxt.pc_next = skip_take ? pc_skip : pc_seq;
			end
			default: res_nxt.pc_next = pc_seq; // illegal code: plain advance, no writes
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencing: results are captured at issue, done marks the last cycle

	exec_pkg::state_type state_r, state_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic done_nxt;
	wire logic accept = issue && ready;
	assign ready = (state_r == exec_pkg::st_idle);

	// counter holds the cycles still to run after the current one
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		unique case (state_r)
			exec_pkg::st_idle: begin
				if (accept && cycles == exec_pkg::CYC_SINGLE) begin
					done_nxt = 1'b1;
				end else if (accept) begin
					state_nxt = exec_pkg::st_busy;
					cnt_nxt = cycles - 3'h1;
				end
			end
			exec_pkg::st_busy: begin
				cnt_nxt = cnt_r - 3'h1;
				if (cnt_r == 3'h1) begin
					state_nxt = exec_pkg::st_idle;
					done_nxt = 1'b1;
				end
			end
		endcase
	end

	// state and handshake
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= exec_pkg::st_idle;
			cnt_r <= 3'h0;
			done <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			done <= done_nxt;
		end
	end

	// result hold, stable until the next accepted issue
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			res <= '0;
		else if (accept)
			res <= res_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	wire logic acc_single = accept && cycles == exec_pkg::CYC_SINGLE;

	sequence busy_then_done_s(logic [2:0] n);
		!done [*1] ##0 (cnt_r == n);
	endsequence

	add_one_cycle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::add_reg_op |=> done && res.rd_res ==
		8'($past(req.rd_val) + $past(req.rr_val)) && res.flag_mask == exec_pkg::MASK_ADD_SUB)
		else $error("add result or timing wrong");

	word_two_cycle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op inside {exec_pkg::word_add_immediate_op, exec_pkg::word_subtract_immediate_op}
		|=> !done ##1 done && res.pair_wr)
		else $error("word operation not two cycles");

	sub_borrow_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::subtract_const_op |=>
		res.flags.c == ($past(req.imm) > $past(req.rd_val)) && res.rd_wr)
		else $error("subtract borrow wrong");

	compare_no_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::immediate_compare_op |=> !res.rd_wr && done)
		else $error("compare wrote a register");

	logic_flags_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::xor_reg_op |=> res.flag_mask == exec_pkg::MASK_LOGIC
		&& !res.flags.v && res.rd_res == ($past(req.rd_val) ^ $past(req.rr_val)))
		else $error("logic flags wrong");

	frac_shift_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && is_frac(op) |=> !res.product_register_pair[0] && !done ##1 done)
		else $error("fractional product not shifted");

	ext_call_five_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::extended_pointer_call_op |=> busy_then_done_s(3'h4)
		##1 !done [*3] ##1 done && res.flag_mask == exec_pkg::MASK_NONE)
		else $error("extended call not five cycles");

	ptr_jump_target_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && op == exec_pkg::pointer_jump_op |=>
		res.pc_next == {6'h00, $past(req.z_ptr)} ##1 done)
		else $error("pointer jump target wrong");

	skip_pc_cycles_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && is_skip(op) && !skip_take |=> done && res.pc_next == $past(req.pc) + 22'h1)
		else $error("skip not taken advanced wrongly");

	skip_two_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && is_skip(op) && skip_take && req.next_two_word |=>
		res.pc_next == $past(req.pc) + 22'h3 ##0 !done [*2] ##1 done)
		else $error("two-word skip wrong");

	single_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_single |=> done && ready)
		else $error("single-cycle operation not done at once");

endmodule : alu_branch_exec

// *** tb/tb_mcu_core_alu_branch_exec.sv ***
// self-checking bench for the arithmetic, multiply, jump and skip execution unit
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_mcu_core_alu_branch_exec;

	typedef struct packed {
		logic [2:0] cyc;
		logic [7:0] mask;
		logic [7:0] flags;
		logic [1:0] cls;
		logic wr;
		logic [15:0] val;
		logic [21:0] pc;
		logic push;
		logic [21:0] ret;
	} exp_type;

	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic issue = 1'b0;
	exec_pkg::request_type req = '0;
	logic ready;
	logic done;
	exec_pkg::result_type res;
	int errors = 0;
	int n_checks = 0;
	int cnt = 0;
	exp_type eq[$];
	int aq[$];

	always #12.5 ref_clk = ~ref_clk;

	alu_branch_exec u_dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.issue(issue),
		.req(req),
		.ready(ready),
		.done(done),
		.res(res)
	);

	////////////////////////////////////////////////////////////////////////////////
	// reference model: result, flags and cycle count of one request
	function automatic exp_type expect_of(input exec_pkg::request_type r);
		exp_type e;
		logic [8:0] s;
		logic [4:0] hc;
		logic [16:0] w;
		logic [15:0] p;
		logic [23:0] x;
		logic [7:0] b;
		logic [7:0] y;
		logic ci, sb, lg, v, tk;
		e = '0;
		{e.cyc, e.wr, e.pc, ci, b, tk} = {3'h1, 1'b1, r.pc + 22'h000001, 1'b0, r.rr_val, 1'b0};
		case (r.op)
			exec_pkg::add_carry_reg_op, exec_pkg::subtract_carry_reg_op: ci = r.carry_in;
			exec_pkg::subtract_const_op, exec_pkg::immediate_compare_op: b = r.imm;
			exec_pkg::subtract_carry_const_op: {b, ci} = {r.imm, r.carry_in};
			default: ;
		endcase
		sb = r.op inside {exec_pkg::subtract_reg_op, exec_pkg::subtract_carry_reg_op,
			exec_pkg::subtract_const_op, exec_pkg::subtract_carry_const_op,
			exec_pkg::immediate_compare_op};
		// subtraction as addition of the inverted operand, borrows are inverted carries
		if (sb) b = ~b;
		s = {1'b0, r.rd_val} + {1'b0, b} + {8'h00, ci ^ sb};
		hc = {1'b0, r.rd_val[3:0]} + {1'b0, b[3:0]} + {4'h0, ci ^ sb};
		{y, lg} = {s[7:0], 1'b1};
		case (r.op)
			exec_pkg::and_reg_op: y = r.rd_val & r.rr_val;
			exec_pkg::and_const_op: y = r.rd_val & r.imm;
			exec_pkg::or_reg_op: y = r.rd_val | r.rr_val;
			exec_pkg::or_const_op, exec_pkg::bit_set_mask_op: y = r.rd_val | r.imm;
			exec_pkg::xor_reg_op: y = r.rd_val ^ r.rr_val;
			exec_pkg::bit_clear_mask_op: y = r.rd_val & (exec_pkg::BYTE_ONES - r.imm);
			exec_pkg::zero_minus_test_op: y = r.rd_val & r.rd_val;
			default: lg = 1'b0;
		endcase
		v = ~lg & ((r.rd_val[7] & b[7] & ~y[7]) | (~r.rd_val[7] & ~b[7] & y[7]));
		e.flags = {2'b00, hc[4] ^ sb, 1'b0, v, y[7], y == 8'h00, s[8] ^ sb};
		e.val = {8'h00, y};
		e.mask = lg ? exec_pkg::MASK_LOGIC : exec_pkg::MASK_ADD_SUB;
		e.wr = r.op != exec_pkg::immediate_compare_op;
		if (r.op inside {exec_pkg::word_add_immediate_op, exec_pkg::word_subtract_immediate_op}) begin
			sb = r.op == exec_pkg::word_subtract_immediate_op;
			w = sb ? {1'b0, r.rdh_val, r.rd_val} - {11'h000, r.imm[5:0]}
				: {1'b0, r.rdh_val, r.rd_val} + {11'h000, r.imm[5:0]};
			v = sb ? (r.rdh_val[7] & ~w[15]) : (~r.rdh_val[7] & w[15]);
			{e.cyc, e.mask, e.cls, e.val} = {exec_pkg::CYC_WORD, exec_pkg::MASK_WORD, 2'h1, w[15:0]};
			e.flags = {3'b000, w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16]};
		end else if (r.op inside {[exec_pkg::unsigned_multiply_op:exec_pkg::fraction_mixed_multiply_op]}) begin
			sb = r.op inside {exec_pkg::signed_multiply_op, exec_pkg::fraction_signed_multiply_op};
			lg = r.op inside {exec_pkg::signed_multiply_op, exec_pkg::mixed_multiply_op,
				exec_pkg::fraction_signed_multiply_op, exec_pkg::fraction_mixed_multiply_op};
			p = $signed({lg & r.rd_val[7], r.rd_val}) * $signed({sb & r.rr_val[7], r.rr_val});
			e.val = (r.op >= exec_pkg::fraction_unsigned_multiply_op) ? {p[14:0], 1'b0} : p;
			{e.cyc, e.mask, e.cls} = {exec_pkg::CYC_MUL, exec_pkg::MASK_MUL, 2'h2};
			e.flags = {6'h00, e.val == 16'h0000, p[15]};
		end else if (r.op >= exec_pkg::pointer_jump_op && r.op != exec_pkg::immediate_compare_op) begin
			x = {r.jump_extension_register, r.z_ptr};
			{e.cls, e.mask, e.wr} = {2'h3, exec_pkg::MASK_NONE, 1'b0};
			case (r.op)
				exec_pkg::pointer_jump_op: {e.cyc, e.pc} = {exec_pkg::CYC_PTR_JUMP, 6'h00, r.z_ptr};
				exec_pkg::extended_pointer_jump_op: {e.cyc, e.pc} = {exec_pkg::CYC_PTR_JUMP, x[21:0]};
				exec_pkg::pointer_call_op: {e.cyc, e.pc} = {exec_pkg::CYC_PTR_CALL, 6'h00, r.z_ptr};
				exec_pkg::extended_pointer_call_op: {e.cyc, e.pc} = {exec_pkg::CYC_EXT_CALL, x[21:0]};
				exec_pkg::direct_call_op: {e.cyc, e.pc} = {exec_pkg::CYC_DIRECT_CALL, r.abs_addr};
				exec_pkg::equal_skip_op: tk = r.rd_val == r.rr_val;
				exec_pkg::reg_bit_clear_skip_op: tk = ~r.rr_val[r.bit_sel];
				exec_pkg::reg_bit_set_skip_op: tk = r.rr_val[r.bit_sel];
				exec_pkg::io_bit_clear_skip_op: tk = ~r.io_val[r.bit_sel];
				exec_pkg::io_bit_set_skip_op: tk = r.io_val[r.bit_sel];
				default: ; // undefined codes: plain advance, nothing written
			endcase
			e.push = r.op inside {exec_pkg::pointer_call_op, exec_pkg::extended_pointer_call_op,
				exec_pkg::direct_call_op};
			if (e.push) e.ret = r.pc + ((r.op == exec_pkg::direct_call_op) ? exec_pkg::ADV_CALL_WORDS
				: exec_pkg::ADV_NEXT);
			if (tk) {e.cyc, e.pc} = r.next_two_word ? {exec_pkg::CYC_SKIP_TWO, r.pc + exec_pkg::ADV_SKIP_TWO}
				: {exec_pkg::CYC_SKIP_ONE, r.pc + exec_pkg::ADV_SKIP_ONE};
		end
		return e;
	endfunction : expect_of

	// random operands for one operation
	function automatic exec_pkg::request_type rnd(input exec_pkg::op_type op);
		exec_pkg::request_type r;
		logic [31:0] t;
		r.op = op;
		{r.rd_val, r.rdh_val, r.rr_val, r.imm} = $urandom;
		{r.io_val, r.z_ptr, r.jump_extension_register} = $urandom;
		t = $urandom;
		r.pc = t[21:0];
		t = $urandom;
		{r.abs_addr, r.bit_sel, r.carry_in, r.next_two_word} = {t[21:0], t[31:27]};
		return r;
	endfunction : rnd

	// chosen operands; word ops see the pair as {b, a}
	function automatic exec_pkg::request_type mk(input exec_pkg::op_type op,
			input logic [7:0] a, input logic [7:0] b, input logic [7:0] k, input logic c);
		exec_pkg::request_type r;
		r = rnd(op);
		{r.rd_val, r.rdh_val, r.rr_val, r.imm, r.carry_in, r.next_two_word} = {a, b, b, k, c, c};
		return r;
	endfunction : mk

	////////////////////////////////////////////////////////////////////////////////
	// monitor: busy window, accepts and completions, all sampled on the edge
	always @(posedge ref_clk) begin
		cnt++;
		// state is unknown before the first reset edge, so nothing is judged while reset stands
		if (sys_rst) begin
			eq.delete();
			aq.delete();
		end else begin
			`CHK(ready, eq.size() == 0 || done === 1'b1)
			if (done === 1'b1 && eq.size() == 0) `CHK(done, 1'b0)
			if (done === 1'b1 && eq.size() > 0) check_done(eq.pop_front(), aq.pop_front());
			if (issue === 1'b1 && ready === 1'b1) begin
				eq.push_back(expect_of(req));
				aq.push_back(cnt);
			end
		end
	end

	task automatic check_done(input exp_type e, input int a);
		`CHK(cnt - a, int'(e.cyc))
		`CHK(res.flag_mask, e.mask)
		`CHK(res.flags & e.mask, e.flags & e.mask)
		if (e.cls == 2'h0) `CHK(res.rd_wr, e.wr)
		if (e.cls == 2'h0 && e.wr) `CHK(res.rd_res, e.val[7:0])
		if (e.cls == 2'h1) `CHK({res.pair_wr, res.rdh_res, res.rd_res}, {1'b1, e.val})
		if (e.cls == 2'h2) `CHK({res.prod_wr, res.product_register_pair}, {1'b1, e.val})
		if (e.cls == 2'h3) `CHK(res.pc_next, e.pc)
		if (e.cls == 2'h3) `CHK({res.push_ret, res.ret_addr}, {e.push, e.ret})
	endtask : check_done

	// hold a request until the unit takes it; issue stays up for back-to-back use
	task automatic send(input exec_pkg::request_type r);
		int w;
		issue <= 1'b1;
		req <= r;
		w = 0;
		do begin
			@(posedge ref_clk);
			w++;
		end while (ready !== 1'b1 && w < 10);
		`CHK(ready, 1'b1)
	endtask : send

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the thousand or so cycles the tests need
	initial begin
		#400000;
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		void'($urandom(32'h8d55));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		// boundary values of carries, overflows, products and targets
		send(mk(exec_pkg::add_reg_op, 8'h80, 8'h80, 8'h00, 1'b0));
		send(mk(exec_pkg::add_carry_reg_op, 8'h0f, 8'h00, 8'h00, 1'b1));
		send(mk(exec_pkg::subtract_reg_op, 8'h00, 8'h01, 8'h00, 1'b0));
		send(mk(exec_pkg::subtract_carry_const_op, 8'h00, 8'h00, 8'h00, 1'b1));
		send(mk(exec_pkg::word_add_immediate_op, 8'hff, 8'hff, 8'h01, 1'b0));
		send(mk(exec_pkg::word_subtract_immediate_op, 8'h00, 8'h80, 8'h01, 1'b0));
		send(mk(exec_pkg::bit_clear_mask_op, 8'hff, 8'h00, 8'h0f, 1'b0));
		send(mk(exec_pkg::signed_multiply_op, 8'h80, 8'h80, 8'h00, 1'b0));
		send(mk(exec_pkg::fraction_mixed_multiply_op, 8'hff, 8'hff, 8'h00, 1'b0));
		send(mk(exec_pkg::equal_skip_op, 8'h5a, 8'h5a, 8'h00, 1'b1));
		send(mk(exec_pkg::extended_pointer_call_op, 8'h00, 8'h00, 8'h00, 1'b0));
		send(mk(exec_pkg::op_type'($urandom_range(63, 33)), 8'h00, 8'h00, 8'h00, 1'b1));
		$display("corner cases done, %0d checks", n_checks);
		// every operation with random operands, issued back to back
		for (int i = 0; i < 33; i++) begin
			repeat (6) send(rnd(exec_pkg::op_type'(i)));
		end
		repeat (300) send(rnd(exec_pkg::op_type'($urandom % 33)));
		$display("random operations done, %0d checks", n_checks);
		// reset in the middle of a long call: no completion may follow
		send(rnd(exec_pkg::direct_call_op));
		issue <= 1'b0;
		sys_rst <= 1'b1;
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
		`CHK(eq.size(), 0)
		`CHK({ready, done}, 2'b10)
		`CHK(res, '0)
		$display("reset during call done, %0d checks", n_checks);
		complete_run();
	end

endmodule : tb_mcu_core_alu_branch_exec
